// *** rtl/let_defs.svh ***
// Register offsets, field positions, reset values and timer constants of the local event table
`ifndef LET_DEFS_SVH
`define LET_DEFS_SVH

`define LET_OFS_TIMER 12'h320
`define LET_OFS_PERF 12'h340
`define LET_OFS_LIN0 12'h350
`define LET_OFS_LIN1 12'h360
`define LET_OFS_START 12'h380
`define LET_OFS_LIVE 12'h390
`define LET_OFS_PRESC 12'h3E0

`define LET_BIT_DLV 12
`define LET_BIT_REMOTE 14
`define LET_BIT_TRIG 15
`define LET_BIT_MASK 16
`define LET_BIT_PERIODIC 17

`define LET_BIT_DIV_HI 3
`define LET_BIT_DIV_MID 1
`define LET_BIT_DIV_LO 0

`define LET_ENTRY_RST 32'h0001_0000
`define LET_COUNT_RST 32'h0000_0000
`define LET_DIVCODE_RST 3'h0
`define LET_VEC_MIN 8'h10
`define LET_NUM_ENTRIES 4

`endif

// *** rtl/let_pkg.sv ***
// Types shared by the local event table and timer
package let_pkg;

    typedef enum logic [2:0] {
        LET_KIND_FIXED = 3'b000,
        LET_KIND_SMI = 3'b010,
        LET_KIND_NMI = 3'b100,
        LET_KIND_EXT = 3'b111
    } let_kind_t;

    typedef enum logic [0:0] {
        LET_HUB_IDLE = 1'b0,
        LET_HUB_BUSY = 1'b1
    } let_hub_t;

    typedef struct packed {
        logic [7:0] vector;
        logic [2:0] kind;
        logic trig;
        logic mask;
        logic periodic;
        logic pend;
        logic dlv;
        logic remote;
        logic err;
    } let_entry_st_t;

    typedef struct packed {
        let_hub_t hubState;
        logic [1:0] srcSel;
        logic reqValid;
        logic [2:0] reqKind;
        logic [7:0] reqVector;
        logic reqLevel;
        logic errPulse;
        logic [31:0] rdData;
        logic rdValid;
        logic [31:0] startCount;
        logic [31:0] liveCount;
        logic [2:0] divCode;
        logic [6:0] prescCnt;
        logic running;
    } let_top_st_t;

endpackage

// *** rtl/let_src_if.sv ***
// Link between one table entry and the delivery hub
`timescale 1ns/1ps
interface let_src_if;
    logic valid;
    logic [2:0] kind;
    logic [7:0] vector;
    logic level;
    logic err;
    logic [31:0] word;
    logic grant;
    logic end_of_service_msg;

    modport entry (output valid, kind, vector, level, err, word, input grant, end_of_service_msg);
    modport hub (input valid, kind, vector, level, err, word, output grant, end_of_service_msg);
endinterface

// *** rtl/let_entry.sv ***
// One local event table entry: configuration, pending request, delivery and remote-pending flags
`timescale 1ns/1ps
`include "let_defs.svh"
module let_entry
    import let_pkg::*;
#(
    parameter bit IS_TIMER = 1'b0,
    parameter bit IS_LOCAL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Software write of this entry
    input wire logic wrEn,
    input wire logic [31:0] wrData,
    // Source event, one-cycle pulse
    input wire logic evt,
    // Towards the delivery hub
    let_src_if.entry src
);

    let_entry_st_t st_r;
    let_entry_st_t st_nxt;
    logic levelEff;
    logic take;

    ////////////////////////////////////////////////////////////////////////
    // SYSTEM_MGMT_INT and NMI edge only
    // Trigger kind counts for fixed only
    assign levelEff = IS_LOCAL && st_r.trig && (st_r.kind == LET_KIND_FIXED);
    assign take = st_r.pend && !st_r.dlv && !st_r.remote;

    always_comb begin
        st_nxt = st_r;
        st_nxt.err = 1'b0;
        if (src.end_of_service_msg) begin
            st_nxt.remote = 1'b0;
        end
        if (st_r.dlv && src.grant) begin
            st_nxt.dlv = 1'b0;
            if (levelEff) begin
                st_nxt.remote = 1'b1;
            end
        end
        if (take) begin
            st_nxt.pend = 1'b0;
            if (st_r.kind == LET_KIND_FIXED && st_r.vector < `LET_VEC_MIN) begin
                st_nxt.err = 1'b1;
            end else begin
                st_nxt.dlv = 1'b1;
            end
        end
        if (evt && !st_r.mask) begin
            st_nxt.pend = 1'b1;
        end
        if (wrEn) begin
            st_nxt.vector = wrData[7:0];
            st_nxt.kind = wrData[10:8];
            st_nxt.trig = wrData[`LET_BIT_TRIG];
            st_nxt.mask = wrData[`LET_BIT_MASK];
            st_nxt.periodic = IS_TIMER ? wrData[`LET_BIT_PERIODIC] : 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '{vector: 8'h00, kind: 3'h0, trig: 1'b0, mask: 1'(`LET_ENTRY_RST >> `LET_BIT_MASK),
                      periodic: 1'b0, pend: 1'b0, dlv: 1'b0, remote: 1'b0, err: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector travels with the request
    assign src.valid = st_r.dlv;
    assign src.kind = st_r.kind;
    assign src.vector = st_r.vector;
    assign src.level = levelEff;
    assign src.err = st_r.err;
    assign src.word = {14'h0000, st_r.periodic, st_r.mask, st_r.trig, st_r.remote, 1'b0, st_r.dlv,
                       1'b0, st_r.kind, st_r.vector};

endmodule

// *** rtl/let_event_timer.sv ***
// Local event table with delivery hub, register port and 32-bit countdown timer
//
// Contract
// - Fixed kind sends the entry's vector
// - Fixed vector below sixteen raises error
// - Kind field selects fixed, SYSTEM_MGMT_INT, NMI, external
// - Delivery flag set until core accepts
// - Remote flag on level acceptance, cleared by service end
// - Remote flag holds further local requests
// - Trigger bit level/edge; SYSTEM_MGMT_INT, NMI edge
// - Local trigger kind applies only fixed
// - Mask bit one blocks reception
// - Timer periodic select: one periodic
// - 32-bit down counter interrupts at zero
// - Periodic mode reloads and continues
// - Live count loads full start count
// - Three-bit code picks clock divisor
// - Local input message raises local event
// - Counter overflow raises masked event
`timescale 1ns/1ps
`include "let_defs.svh"
module let_event_timer
    import let_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port, dword accesses
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Event sources
    input wire logic perfOverflow,
    input wire logic lintMsgValid,
    input wire logic lintMsgSel,
    // End of service from the core handler
    input wire logic eoiValid,
    input wire logic [7:0] eoiVector,
    // Delivery to the core handler
    output logic coreReqValid,
    output logic [2:0] coreReqKind,
    output logic [7:0] coreReqVector,
    output logic coreReqLevel,
    input wire logic coreAccept,
    // Error report
    output logic illegalVecErr
);

    localparam int NENT = `LET_NUM_ENTRIES;
    localparam logic [11:0] ENT_OFS [NENT] = '{`LET_OFS_TIMER, `LET_OFS_PERF, `LET_OFS_LIN0, `LET_OFS_LIN1};

    let_top_st_t st_r;
    let_top_st_t st_nxt;

    logic [NENT-1:0] entValid;
    logic [NENT-1:0] entLevel;
    logic [NENT-1:0] entErr;
    logic [NENT-1:0] entWr;
    logic [NENT-1:0] entEvt;
    logic [NENT-1:0] grantVec;
    logic [2:0] entKind [NENT];
    logic [7:0] entVector [NENT];
    logic [31:0] entWord [NENT];
    logic timerEvt;
    logic tick;
    logic timerPeriodic;

    ////////////////////////////////////////////////////////////////////////
    // Table entries
    let_src_if src [NENT] ();

    for (genvar i = 0; i < NENT; i++) begin : gEnt
        let_entry #(
            .IS_TIMER(i == 0),
            .IS_LOCAL(i >= 2)
        ) uEntry (
            .clock(clock),
            .rst(rst),
            .wrEn(entWr[i]),
            .wrData(regWrData),
            .evt(entEvt[i]),
            .src(src[i])
        );
        assign entValid[i] = src[i].valid;
        assign entLevel[i] = src[i].level;
        assign entErr[i] = src[i].err;
        assign entKind[i] = src[i].kind;
        assign entVector[i] = src[i].vector;
        assign entWord[i] = src[i].word;
        assign entWr[i] = regWr && (regAddr == ENT_OFS[i]);
        assign src[i].grant = grantVec[i];
        assign src[i].end_of_service_msg = eoiValid && (eoiVector == src[i].vector);
    end

    // Expiry feeds the masked timer entry
    assign entEvt[0] = timerEvt;
    assign entEvt[1] = perfOverflow;
    assign entEvt[2] = lintMsgValid && !lintMsgSel;
    assign entEvt[3] = lintMsgValid && lintMsgSel;

    assign timerPeriodic = entWord[0][`LET_BIT_PERIODIC];

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    // Divisor from code bits
    function automatic logic [6:0] divLimit(input logic [2:0] code);
        case (code)
            3'h0: divLimit = 7'h01;
            3'h1: divLimit = 7'h03;
            3'h2: divLimit = 7'h07;
            3'h3: divLimit = 7'h0F;
            3'h4: divLimit = 7'h1F;
            3'h5: divLimit = 7'h3F;
            3'h6: divLimit = 7'h7F;
            default: divLimit = 7'h00;
        endcase
    endfunction

    assign tick = (st_r.prescCnt >= divLimit(st_r.divCode));
    assign timerEvt = tick && st_r.running && (st_r.liveCount == 32'h0000_0001);

    always_comb begin
        grantVec = '0;
        if (st_r.hubState == LET_HUB_BUSY && coreAccept) begin
            grantVec[st_r.srcSel] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.errPulse = |entErr;
        st_nxt.rdValid = regRd;

        // Delivery hub; lowest index wins when several wait
        case (st_r.hubState)
            LET_HUB_IDLE: begin
                for (int i = NENT - 1; i >= 0; i--) begin
                    if (entValid[i]) begin
                        st_nxt.srcSel = 2'(i);
                        // Kind passed on to the core
                        st_nxt.reqKind = entKind[i];
                        st_nxt.reqVector = entVector[i];
                        st_nxt.reqLevel = entLevel[i];
                        st_nxt.reqValid = 1'b1;
                        st_nxt.hubState = LET_HUB_BUSY;
                    end
                end
            end
            LET_HUB_BUSY: begin
                if (coreAccept) begin
                    st_nxt.reqValid = 1'b0;
                    st_nxt.hubState = LET_HUB_IDLE;
                end
            end
            default: begin
                st_nxt.hubState = LET_HUB_IDLE;
            end
        endcase

        // Countdown
        st_nxt.prescCnt = tick ? 7'h00 : st_r.prescCnt + 7'h01;
        if (tick && st_r.running) begin
            if (st_r.liveCount == 32'h0000_0001) begin
                if (timerPeriodic && st_r.startCount != 32'h0000_0000) begin
                    st_nxt.liveCount = st_r.startCount;
                end else begin
                    st_nxt.liveCount = 32'h0000_0000;
                    st_nxt.running = 1'b0;
                end
            end else if (st_r.liveCount == 32'h0000_0000) begin
                st_nxt.running = 1'b0;
            end else begin
                st_nxt.liveCount = st_r.liveCount - 32'h0000_0001;
            end
        end

        // Register writes; reserved bits are not stored
        if (regWr) begin
            if (regAddr == `LET_OFS_START) begin
                st_nxt.startCount = regWrData;
                st_nxt.liveCount = regWrData;
                st_nxt.running = (regWrData != 32'h0000_0000);
                st_nxt.prescCnt = 7'h00;
            end else if (regAddr == `LET_OFS_PRESC) begin
                st_nxt.divCode = {regWrData[`LET_BIT_DIV_HI], regWrData[`LET_BIT_DIV_MID],
                                  regWrData[`LET_BIT_DIV_LO]};
            end
        end

        // Register reads; unmapped offsets read as zero
        if (regRd) begin
            if (regAddr == `LET_OFS_TIMER) begin
                st_nxt.rdData = entWord[0];
            end else if (regAddr == `LET_OFS_PERF) begin
                st_nxt.rdData = entWord[1];
            end else if (regAddr == `LET_OFS_LIN0) begin
                st_nxt.rdData = entWord[2];
            end else if (regAddr == `LET_OFS_LIN1) begin
                st_nxt.rdData = entWord[3];
            end else if (regAddr == `LET_OFS_START) begin
                st_nxt.rdData = st_r.startCount;
            end else if (regAddr == `LET_OFS_LIVE) begin
                st_nxt.rdData = st_r.liveCount;
            end else if (regAddr == `LET_OFS_PRESC) begin
                st_nxt.rdData = {28'h000_0000, st_r.divCode[2], 1'b0, st_r.divCode[1:0]};
            end else begin
                st_nxt.rdData = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= '{hubState: LET_HUB_IDLE, srcSel: 2'h0, reqValid: 1'b0, reqKind: 3'h0,
                      reqVector: 8'h00, reqLevel: 1'b0, errPulse: 1'b0, rdData: 32'h0000_0000,
                      rdValid: 1'b0, startCount: `LET_COUNT_RST, liveCount: `LET_COUNT_RST,
                      divCode: `LET_DIVCODE_RST, prescCnt: 7'h00, running: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign regRdData = st_r.rdData;
    assign regRdValid = st_r.rdValid;
    assign coreReqValid = st_r.reqValid;
    assign coreReqKind = st_r.reqKind;
    assign coreReqVector = st_r.reqVector;
    assign coreReqLevel = st_r.reqLevel;
    assign illegalVecErr = st_r.errPulse;

endmodule

// *** test/let_event_timer_assertions.sv ***
// Port-level checks for the local event table and timer
`timescale 1ns/1ps
`include "let_defs.svh"
module let_event_timer_assertions
    import let_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic regRd,
    input wire logic [11:0] regAddr,
    input logic [31:0] regRdData,
    input logic regRdValid,
    // End of service
    input wire logic eoiValid,
    input wire logic [7:0] eoiVector,
    // Delivery
    input logic coreReqValid,
    input logic [2:0] coreReqKind,
    input logic [7:0] coreReqVector,
    input logic coreReqLevel,
    input wire logic coreAccept,
    input logic illegalVecErr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff rst;

    ////////////////////////////////////////////////////////////////
    // Shadow of the remote flag; one level source at a time is assumed
    logic heldValid_r;
    logic [7:0] heldVector_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            heldValid_r <= 1'b0;
            heldVector_r <= 8'h0;
        end else if (coreReqValid && coreAccept && coreReqLevel) begin
            heldValid_r <= 1'b1;
            heldVector_r <= coreReqVector;
        end else if (eoiValid && eoiVector == heldVector_r) begin
            heldValid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence s_waiting;
        coreReqValid && !coreAccept;
    endsequence
    sequence s_taken;
        coreReqValid && coreAccept;
    endsequence

    a_reset_quiet: assert property ($past(rst) |-> !coreReqValid && !regRdValid && !illegalVecErr && regRdData == 32'h0)
        else $error("outputs active after reset");
    a_read_latency: assert property (regRd |=> regRdValid)
        else $error("read answer missing");
    a_read_origin: assert property (regRdValid |-> $past(regRd))
        else $error("read answer without read");
    a_unmapped_zero: assert property (regRd && !(regAddr inside {`LET_OFS_TIMER, `LET_OFS_PERF, `LET_OFS_LIN0,
        `LET_OFS_LIN1, `LET_OFS_START, `LET_OFS_LIVE, `LET_OFS_PRESC}) |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_request_stands: assert property (s_waiting |=> coreReqValid && $stable({coreReqKind, coreReqVector, coreReqLevel}))
        else $error("request changed before accept");
    a_accept_drops: assert property (s_taken |=> !coreReqValid)
        else $error("request stays after accept");
    a_fixed_legal: assert property (coreReqValid && coreReqKind == LET_KIND_FIXED |-> coreReqVector >= `LET_VEC_MIN)
        else $error("illegal vector delivered");
    a_level_fixed: assert property (coreReqValid && coreReqLevel |-> coreReqKind == LET_KIND_FIXED)
        else $error("level request of non-fixed kind");
    a_remote_blocks: assert property (coreReqValid && coreReqLevel && heldValid_r |-> coreReqVector != heldVector_r)
        else $error("request forwarded while remote pending");
endmodule

bind let_event_timer let_event_timer_assertions let_event_timer_assertions_i (.*);

// *** test/let_core_model.sv ***
// Core handler model: takes requests after a set delay and returns end of service
`timescale 1ns/1ps
module let_core_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Requests from the table
    input wire logic coreReqValid,
    input wire logic [2:0] coreReqKind,
    input wire logic [7:0] coreReqVector,
    input wire logic coreReqLevel,
    output logic coreAccept = 1'b0,
    // End of service
    output logic eoiValid = 1'b0,
    output logic [7:0] eoiVector = 8'h5A,
    // Bench control and record
    input wire logic [4:0] acceptDelay,
    input wire logic eoiReq,
    output logic [7:0] gotCount,
    output logic [2:0] gotKind,
    output logic [7:0] gotVector,
    output logic gotLevel
);
    logic [4:0] waitCnt;
    always @(posedge clock) begin
        eoiValid <= eoiReq && !rst;
        // Idle vector keeps moving so a stale value never matches by luck
        eoiVector <= eoiReq ? gotVector : ~eoiVector;
        if (rst) begin
            coreAccept <= 1'b0;
            waitCnt <= 5'h0;
            gotCount <= 8'h0;
        end else if (coreAccept && coreReqValid) begin
            coreAccept <= 1'b0;
            waitCnt <= 5'h0;
            gotCount <= gotCount + 8'h1;
            gotKind <= coreReqKind;
            gotVector <= coreReqVector;
            gotLevel <= coreReqLevel;
        end else if (coreReqValid && waitCnt >= acceptDelay) begin
            coreAccept <= 1'b1;
        end else if (coreReqValid) begin
            waitCnt <= waitCnt + 5'h1;
        end
    end
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the local event table and timer
`timescale 1ns/1ps
`include "let_defs.svh"
`define CHK(nm, e, g) \
    begin \
        comparisons++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("wrong value %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_top;
    import let_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic regWr = 1'b0, regRd = 1'b0, perfOverflow = 1'b0, lintMsgValid = 1'b0, lintMsgSel = 1'b0, eoiReq = 1'b0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWrData = 32'h0;
    logic [4:0] acceptDelay = 5'h0;
    logic [31:0] regRdData, d;
    logic regRdValid, eoiValid, coreReqValid, coreReqLevel, coreAccept, illegalVecErr, gotLevel;
    logic [7:0] eoiVector, coreReqVector, gotCount, gotVector;
    logic [2:0] coreReqKind, gotKind;
    logic [2:0] kinds [3] = '{3'h2, 3'h4, 3'h7};
    int num_errors = 0, comparisons = 0, errSeen = 0, waited, e0;

    let_event_timer let_event_timer_i (.*);
    let_core_model let_core_model_i (.*);
    always #2 clock = ~clock;
    always @(posedge clock) if (illegalVecErr === 1'b1) errSeen <= errSeen + 1;

    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        `CHK("register", {1'b1, e}, {regRdValid, regRdData})
    endtask
    task automatic pulse(input logic perf, input logic sel);
        @(posedge clock);
        perfOverflow <= perf;
        lintMsgValid <= !perf;
        lintMsgSel <= sel;
        @(posedge clock);
        perfOverflow <= 1'b0;
        lintMsgValid <= 1'b0;
    endtask
    task automatic end_of_service_msg();
        @(posedge clock);
        eoiReq <= 1'b1;
        @(posedge clock);
        eoiReq <= 1'b0;
    endtask
    // Vector only compared for fixed kind, where it carries meaning
    task automatic expectGot(input logic [2:0] k, input logic [7:0] v, input logic l);
        logic [7:0] c0;
        c0 = gotCount;
        waited = 0;
        while (gotCount === c0 && waited < 2000) begin
            @(negedge clock);
            waited++;
        end
        `CHK("delivery", {1'b1, k, v, l}, {gotCount !== c0, gotKind, k == 3'h0 ? gotVector : v, gotLevel})
    endtask
    task automatic expectNone(input int cy);
        logic [7:0] c0;
        c0 = gotCount;
        repeat (cy) @(posedge clock);
        `CHK("no delivery", c0, gotCount)
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(`LET_OFS_TIMER, `LET_ENTRY_RST);
        rd(`LET_OFS_PERF, `LET_ENTRY_RST);
        rd(`LET_OFS_LIN1, `LET_ENTRY_RST);
        rd(`LET_OFS_START, 32'h0);
        rd(`LET_OFS_PRESC, 32'h0);
        rd(12'h370, 32'h0);
        wr(`LET_OFS_LIVE, 32'h1234_5678);
        rd(`LET_OFS_LIVE, 32'h0);
        wr(`LET_OFS_PRESC, 32'h0000_000A);
        wr(`LET_OFS_START, 32'hFFFF_FFFF);
        rd(`LET_OFS_LIVE, 32'hFFFF_FFFF);
        rd(`LET_OFS_PRESC, 32'h0000_000A);
        wr(`LET_OFS_START, 32'h0);
        $display("test registers done");
        acceptDelay <= 5'h3;
        wr(`LET_OFS_LIN0, 32'h0000_8040);
        pulse(1'b0, 1'b0);
        expectGot(3'h0, 8'h40, 1'b1);
        rd(`LET_OFS_LIN0, 32'h0000_C040);
        pulse(1'b0, 1'b0);
        expectNone(20);
        end_of_service_msg();
        expectGot(3'h0, 8'h40, 1'b1);
        end_of_service_msg();
        rd(`LET_OFS_LIN0, 32'h0000_8040);
        $display("test level input done");
        wr(`LET_OFS_LIN1, 32'h0001_0050);
        pulse(1'b0, 1'b1);
        expectNone(20);
        for (int i = 0; i < 3; i++) begin
            d = {16'h0, 1'b1, 4'h0, kinds[i], kinds[i] == 3'h2 ? 8'h00 : 8'h50};
            wr(`LET_OFS_LIN1, d);
            pulse(1'b0, 1'b1);
            expectGot(kinds[i], d[7:0], 1'b0);
            rd(`LET_OFS_LIN1, d);
        end
        wr(`LET_OFS_LIN1, 32'h0000_0051);
        pulse(1'b0, 1'b1);
        expectGot(3'h0, 8'h51, 1'b0);
        $display("test message kinds done");
        e0 = errSeen;
        wr(`LET_OFS_PERF, 32'h0000_000F);
        pulse(1'b1, 1'b0);
        expectNone(10);
        `CHK("vector error", e0 + 1, errSeen)
        acceptDelay <= 5'h14;
        wr(`LET_OFS_PERF, 32'h0000_0010);
        pulse(1'b1, 1'b0);
        repeat (4) @(posedge clock);
        rd(`LET_OFS_PERF, 32'h0000_1010);
        expectGot(3'h0, 8'h10, 1'b0);
        rd(`LET_OFS_PERF, 32'h0000_0010);
        acceptDelay <= 5'h0;
        $display("test counter overflow done");
        wr(`LET_OFS_TIMER, 32'h0000_0030);
        for (int c = 0; c < 8; c++) begin
            wr(`LET_OFS_PRESC, {28'h0, c[2], 1'b0, c[1:0]});
            wr(`LET_OFS_START, 32'h0000_0008);
            expectGot(3'h0, 8'h30, 1'b0);
            d = c == 7 ? 32'h8 : 32'h8 << (c + 1);
            `CHK("expiry time", 1'b1, waited >= d + 4 && waited <= d + 9)
        end
        expectNone(40);
        rd(`LET_OFS_LIVE, 32'h0);
        wr(`LET_OFS_TIMER, 32'h0003_0030);
        wr(`LET_OFS_START, 32'h0000_0008);
        expectNone(40);
        wr(`LET_OFS_TIMER, 32'h0002_0030);
        expectGot(3'h0, 8'h30, 1'b0);
        expectGot(3'h0, 8'h30, 1'b0);
        `CHK("period", 8, waited)
        wr(`LET_OFS_START, 32'h0);
        $display("test timer done");
        conclude();
    end
    // Whole run needs a few thousand cycles
    initial begin
        #80000;
        num_errors++;
        conclude();
    end
endmodule
